// File: common/dac_cfg.svh
/*
 * constants for the converter control block: register map, field positions,
 * reset values and timing counts.
 * assumes a 20 mhz system clock standing in for the sampling clock.
 */
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH
// register byte offsets on the ahb-lite bus
`define DAC_OFS_RESET 12'h000
`define DAC_OFS_DIGEN 12'h004
`define DAC_OFS_GAIN 12'h008
`define DAC_OFS_DCCTL 12'h00C
`define DAC_OFS_PWR 12'h010
`define DAC_OFS_SERIAL 12'h014
`define DAC_OFS_STATUS 12'h018
`define DAC_OFS_SAMPLE 12'h01C
`define DAC_OFS_OFSA 12'h020
`define DAC_OFS_OFSB 12'h024
// dc control fields
`define DAC_DC_EN_BIT 0
`define DAC_DC_HOLD_BIT 1
`define DAC_DC_TC_LSB 4
// power register codes
`define DAC_PWR_NORMAL 3'h0
`define DAC_PWR_DOWN 3'h4
`define DAC_PWR_STBY_A 3'h5
`define DAC_PWR_MUX 3'h7
// reset values and the largest time constant code
`define DAC_GAIN_RST 4'h0
`define DAC_DCCTL_RST 8'h02
`define DAC_TC_MAX 4'hB
// latencies in sampling cycles
`define DAC_RAW_LAT 16
`define DAC_DIG_EXTRA 4
// timing
`define DAC_CLK_MHZ 20
`define DAC_WAKE_GLOBAL_US 100
`define DAC_WAKE_STBY_US 50
`define DAC_WAKE_GLOBAL_CYC (`DAC_WAKE_GLOBAL_US * `DAC_CLK_MHZ)
`define DAC_WAKE_STBY_CYC (`DAC_WAKE_STBY_US * `DAC_CLK_MHZ)
`define DAC_SLOW_US 1
`define DAC_SLOW_CYC (`DAC_SLOW_US * `DAC_CLK_MHZ)
`endif

// File: common/dac_pkg.sv
/*
 * types shared by the converter control block.
 * assumes nothing beyond a systemverilog compiler.
 */
package dac_pkg;
  typedef enum logic [1:0] {
    DAC_CFG_SERIAL,
    DAC_CFG_MIXED,
    DAC_CFG_PARALLEL
  } dac_cfg_t;
  typedef enum logic [2:0] {
    DAC_MODE_NORMAL,
    DAC_MODE_DOWN,
    DAC_MODE_STBY_A,
    DAC_MODE_MUX,
    DAC_MODE_BAD
  } dac_mode_t;
endpackage

// File: design/dac_ctrl.sv
/*
 * dual channel converter control: sample pipeline with gain and dc offset
 * correction, power mode decode, pin/serial/mixed configuration, and an
 * ahb-lite register slave.
 * assumes one clock (the sampling clock) and pins synchronous to it.
 */
`timescale 1ns/1ps
`include "dac_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - raw samples reach outputs after exactly 16 cycles when features off
// - enabling any digital feature adds extra pipeline cycles
// - feature settings act only once digital enable is set
// - gain 0 to 6 dB in half-dB steps, full scale shrinks
// - gain returns to 0 dB on every reset
// - dc correction estimates each channel offset, subtracts every cycle
// - 4-bit time constant 1M doubling to 2G; codes 12-15 reserved
// - hold bit at 0 freezes estimate, last value still applied
// - offset correction is off after every reset
// - power pins decode normal, power-down, A standby, mux
// - mux mode interleaves both channels onto channel B bus
// - power-down tristates outputs, data valid 100 us after release
// - standby powers down channel A only, valid within 50 us
// - slow sampling clock enters low-power state automatically
// - reset pin held high selects parallel pin configuration
// - parallel mode: select pin is format, shift clock is low speed
// - reset pulse or reset bit restores register defaults
// - mixed mode configures from power pins and accepts serial writes
// - serial words 16 bits on falling edges, partial words dropped
// - the reset bit clears itself after the software reset
module dac_ctrl #(
  parameter int DW = 14,
  parameter int WAKE_GLOBAL = `DAC_WAKE_GLOBAL_CYC,
  parameter int WAKE_STBY = `DAC_WAKE_STBY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // device pins
  input wire logic reset_pin,
  input wire logic power_ctrl_pin_1,
  input wire logic power_ctrl_pin_2,
  input wire logic power_ctrl_pin_3,
  input wire logic serial_select_n,
  input wire logic serial_shift_clock,
  input wire logic serial_data_input,
  input wire logic sample_strobe,
  // converter samples
  input wire logic [DW-1:0] raw_a,
  input wire logic [DW-1:0] raw_b,
  // outputs
  output logic [DW-1:0] channel_a_output_bus,
  output logic [DW-1:0] channel_b_output_bus,
  output logic out_a_oe,
  output logic out_b_oe,
  output logic data_valid,
  output logic low_power,
  output logic low_speed,
  output logic format_select,
  output logic [1:0] config_mode
);
  import dac_pkg::*;

  localparam int LAT = `DAC_RAW_LAT;
  localparam int EXTRA = `DAC_DIG_EXTRA;
  // the output flop is the last stage of either path
  localparam int DEPTH = LAT + EXTRA - 1;
  localparam int WAKE_W = $clog2(WAKE_GLOBAL + 1);
  localparam int ACC_W = DW + 32;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic soft_reset;
  logic digital_features_enable;
  logic [3:0] gain_code;
  logic dc_correction_enable;
  logic dc_correction_hold;
  logic [3:0] dc_correction_time_constant;
  logic [2:0] pwr_code;
  logic full_power_down_bit;
  logic [15:0] serial_last;
  logic reg_init;
  dac_cfg_t cfg;
  logic rst_pin_d;
  logic pin_mode_used;
  logic [31:0] rd_data;

  // register defaults come from the pin pulse, the bit or the bus reset
  wire rst_regs = soft_reset || (reset_pin && cfg != DAC_CFG_PARALLEL
                                 && !rst_pin_d);

  ////////////////////////////////////////////////////////////////////////////
  // configuration select: a long high on the reset pin means parallel
  logic [7:0] high_cnt;
  wire [7:0] next_high_cnt = reset_pin ? (high_cnt == 8'hFF ? high_cnt :
                             high_cnt + 8'h01) : 8'h00;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      high_cnt <= 8'h00;
      rst_pin_d <= 1'b0;
      cfg <= DAC_CFG_MIXED;
    end else begin
      high_cnt <= next_high_cnt;
      rst_pin_d <= reset_pin;
      if (high_cnt == 8'hFF)
        cfg <= DAC_CFG_PARALLEL;
      else if (!reset_pin && cfg == DAC_CFG_PARALLEL)
        cfg <= DAC_CFG_MIXED;
      else if (!reset_pin && reg_init && !pin_mode_used)
        cfg <= DAC_CFG_SERIAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // three wire serial port, falling edge of shift clock sampled on clk
  logic sclk_d;
  logic [15:0] sh;
  logic [3:0] bit_cnt;
  wire parallel = (cfg == DAC_CFG_PARALLEL);
  wire sfall = sclk_d && !serial_shift_clock && !serial_select_n && !parallel;
  wire word_done = sfall && bit_cnt == 4'hF;
  wire [15:0] word = {sh[14:0], serial_data_input};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
      sh <= 16'h0000;
      bit_cnt <= 4'h0;
    end else begin
      sclk_d <= serial_shift_clock;
      if (serial_select_n) begin
        bit_cnt <= 4'h0; // trailing partial bits dropped
      end else if (sfall) begin
        sh <= word;
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite: address phase captured, write applied in data phase
  logic wr_pend;
  logic [11:0] wr_addr;
  wire take = hsel && hready && htrans[1];
  wire bus_wr = wr_pend;
  // a serial word's upper byte is a register index; times four it addresses the bus byte offset map
  wire [11:0] w_addr = bus_wr ? wr_addr : {2'h0, word[15:8], 2'h0};
  wire [7:0] w_data = bus_wr ? hwdata[7:0] : word[7:0];
  wire w_en = bus_wr || word_done;
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = w_en && a == o;
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= take && hwrite;
      if (take)
        wr_addr <= haddr;
    end
  end

  // control registers; the bus reset and the soft reset share defaults
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soft_reset <= 1'b0;
      digital_features_enable <= 1'b0;
      gain_code <= `DAC_GAIN_RST;
      dc_correction_enable <= 1'b0;
      dc_correction_hold <= 1'b1;
      dc_correction_time_constant <= 4'h0;
      pwr_code <= `DAC_PWR_NORMAL;
      full_power_down_bit <= 1'b0;
      serial_last <= 16'h0000;
      reg_init <= 1'b0;
      pin_mode_used <= 1'b1;
    end else if (rst_regs) begin
      soft_reset <= 1'b0; // self clears once defaults are back
      digital_features_enable <= 1'b0;
      gain_code <= `DAC_GAIN_RST;
      dc_correction_enable <= 1'b0;
      dc_correction_hold <= 1'b1;
      dc_correction_time_constant <= 4'h0;
      pwr_code <= `DAC_PWR_NORMAL;
      full_power_down_bit <= 1'b0;
      reg_init <= 1'b1;
      // pins keep control after a register reset; a power write hands over
      pin_mode_used <= 1'b1;
    end else begin
      if (word_done)
        serial_last <= word;
      if (hit(w_addr, `DAC_OFS_RESET))
        soft_reset <= w_data[0];
      if (hit(w_addr, `DAC_OFS_DIGEN))
        digital_features_enable <= w_data[0];
      if (hit(w_addr, `DAC_OFS_GAIN) && w_data[3:0] <= 4'hC)
        gain_code <= w_data[3:0]; // steps of 0.5 dB up to 6 dB
      if (hit(w_addr, `DAC_OFS_DCCTL)) begin
        dc_correction_enable <= w_data[`DAC_DC_EN_BIT];
        dc_correction_hold <= w_data[`DAC_DC_HOLD_BIT];
        if (w_data[7:4] <= `DAC_TC_MAX)
          dc_correction_time_constant <= w_data[7:4]; // reserved kept
      end
      if (hit(w_addr, `DAC_OFS_PWR)) begin
        pwr_code <= w_data[2:0];
        full_power_down_bit <= w_data[3];
        pin_mode_used <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode decode from pins or register
  wire [2:0] pins = {power_ctrl_pin_1, power_ctrl_pin_2, power_ctrl_pin_3};
  wire use_pins = parallel || cfg == DAC_CFG_MIXED;
  wire [2:0] code = use_pins && pins != 3'h0 ? pins : pwr_code;
  function automatic dac_mode_t decode(input logic [2:0] c);
    case (c)
      `DAC_PWR_NORMAL: decode = DAC_MODE_NORMAL;
      `DAC_PWR_DOWN: decode = DAC_MODE_DOWN;
      `DAC_PWR_STBY_A: decode = DAC_MODE_STBY_A;
      `DAC_PWR_MUX: decode = DAC_MODE_MUX;
      default: decode = DAC_MODE_BAD;
    endcase
  endfunction
  wire dac_mode_t mode_raw = decode(code);
  wire dac_mode_t mode = full_power_down_bit ? DAC_MODE_DOWN : mode_raw;
  wire is_down = mode == DAC_MODE_DOWN;
  wire is_stby = mode == DAC_MODE_STBY_A; // only channel A sleeps

  ////////////////////////////////////////////////////////////////////////////
  // slow clock detect: no sample strobe for a microsecond means slow
  logic [7:0] gap;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      gap <= 8'h00;
    else if (sample_strobe)
      gap <= 8'h00;
    else if (gap != 8'hFF)
      gap <= gap + 8'h01;
  end
  wire slow = gap >= 8'(`DAC_SLOW_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // wake timers: after power-down, valid data only once the wake time expires; standby release keeps it one more cycle
  logic [WAKE_W-1:0] wake;
  logic was_down;
  logic was_stby;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake <= '0;
      was_down <= 1'b0;
      was_stby <= 1'b0;
    end else begin
      was_down <= is_down;
      was_stby <= is_stby;
      if (was_down && !is_down)
        wake <= WAKE_W'(WAKE_GLOBAL);
      else if (was_stby && !is_stby)
        wake <= WAKE_W'(WAKE_STBY);
      else if (wake != '0)
        wake <= wake - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample pipeline; digital path uses a longer tap
  logic [DW-1:0] pa [DEPTH];
  logic [DW-1:0] pb [DEPTH];
  logic signed [ACC_W-1:0] acc_a;
  logic signed [ACC_W-1:0] acc_b;
  logic signed [DW-1:0] ofs_a;
  logic signed [DW-1:0] ofs_b;
  wire dig = digital_features_enable; // settings gated by enable
  wire [5:0] tc_sh = 6'(dc_correction_time_constant) + 6'd20;

  // gain scale factor 256 + 22*g in q8, about twice at g=12, applied to the digital path only
  function automatic logic [DW-1:0] scale(input logic [DW-1:0] s,
                                          input logic [3:0] g);
    logic [9:0] k;
    logic signed [DW+10:0] p;
    k = 10'd256 + 10'(g) * 10'd22;
    p = $signed({s[DW-1], s}) * $signed({1'b0, k});
    scale = p[DW+7:8];
  endfunction

  wire [DW-1:0] ca = scale(pa[LAT-1], gain_code) - ofs_a;
  wire [DW-1:0] cb = scale(pb[LAT-1], gain_code) - ofs_b;

  always_ff @(posedge clk) begin
    pa[0] <= raw_a;
    pb[0] <= raw_b;
    for (int i = 1; i < DEPTH; i++) begin
      pa[i] <= (i == LAT) ? ca : pa[i-1];
      pb[i] <= (i == LAT) ? cb : pb[i-1];
    end
  end

  // leaky estimate; hold low freezes it and the old value stays in use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_a <= '0;
      acc_b <= '0;
    end else if (!(dig && dc_correction_enable)) begin
      acc_a <= '0;
      acc_b <= '0;
    end else if (dc_correction_hold) begin
      acc_a <= acc_a + ACC_W'($signed(pa[LAT-1])) - (acc_a >>> tc_sh);
      acc_b <= acc_b + ACC_W'($signed(pb[LAT-1])) - (acc_b >>> tc_sh);
    end
  end
  assign ofs_a = DW'(acc_a >>> tc_sh);
  assign ofs_b = DW'(acc_b >>> tc_sh);

  ////////////////////////////////////////////////////////////////////////////
  // output stage; mux alternates A and B on the B bus
  logic mux_ph;
  wire [DW-1:0] sa = dig ? pa[DEPTH-1] : pa[LAT-2];
  wire [DW-1:0] sb = dig ? pb[DEPTH-1] : pb[LAT-2];
  wire is_mux = mode == DAC_MODE_MUX;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_a_output_bus <= '0;
      channel_b_output_bus <= '0;
      out_a_oe <= 1'b0;
      out_b_oe <= 1'b0;
      data_valid <= 1'b0;
      mux_ph <= 1'b0;
      low_power <= 1'b0;
      low_speed <= 1'b0;
      format_select <= 1'b0;
      config_mode <= 2'h0;
      hrdata <= 32'h0;
    end else begin
      mux_ph <= is_mux ? !mux_ph : 1'b0;
      channel_a_output_bus <= sa;
      channel_b_output_bus <= is_mux && mux_ph ? sa : sb;
      out_a_oe <= !is_down && !is_mux && !is_stby;
      out_b_oe <= !is_down;
      // was_down covers the cycle before the wake timer is loaded
      data_valid <= wake == '0 && !is_down && !was_down &&
                    mode != DAC_MODE_BAD;
      low_power <= is_down || is_stby || slow;
      low_speed <= parallel && serial_shift_clock;
      format_select <= parallel && serial_select_n;
      config_mode <= cfg;
      hrdata <= rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, returned one cycle after the address phase
  assign rd_data =
    haddr == `DAC_OFS_RESET ? {31'h0, soft_reset} :
    haddr == `DAC_OFS_DIGEN ? {31'h0, digital_features_enable} :
    haddr == `DAC_OFS_GAIN ? {28'h0, gain_code} :
    haddr == `DAC_OFS_DCCTL ? {24'h0, dc_correction_time_constant, 2'h0,
                               dc_correction_hold, dc_correction_enable} :
    haddr == `DAC_OFS_PWR ? {28'h0, full_power_down_bit, pwr_code} :
    haddr == `DAC_OFS_SERIAL ? {16'h0, serial_last} :
    haddr == `DAC_OFS_STATUS ? {24'h0, 1'b0, 3'(mode), data_valid,
                                low_power, 2'(cfg)} :
    haddr == `DAC_OFS_OFSA ? 32'(ofs_a) :
    haddr == `DAC_OFS_OFSB ? 32'(ofs_b) :
    32'h0;
endmodule

// File: sim/dac_host.sv
/* controller model: drives the reset pin, the three power pins and the
   three-wire serial port.
   assumes its tasks are entered just after a rising clock edge. */
`timescale 1ns/1ps
module dac_host (
  // clock
  input wire logic clk,
  // pins toward the device
  output logic reset_pin = 1'b0,
  output logic power_ctrl_pin_1 = 1'b0,
  output logic power_ctrl_pin_2 = 1'b0,
  output logic power_ctrl_pin_3 = 1'b0,
  output logic serial_select_n = 1'b1,
  output logic serial_shift_clock = 1'b0,
  output logic serial_data_input = 1'b0
);
  ////////////////////////////////////////
  // static pin levels; reset pin held high means pin-only setup, held low
  // keeps the serial port in use
  task automatic set(input logic [2:0] p, input logic r, sc, sn);
    {power_ctrl_pin_1, power_ctrl_pin_2, power_ctrl_pin_3} <= p;
    reset_pin <= r;
    serial_shift_clock <= sc;
    serial_select_n <= sn;
  endtask
  // one word msb first, n bits only; clock idles low outside frames
  task automatic send(input logic [15:0] w, input int n);
    serial_select_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      serial_data_input <= w[i];
      repeat (2) @(posedge clk);
      serial_shift_clock <= 1'b1;
      repeat (2) @(posedge clk);
      serial_shift_clock <= 1'b0; // falling edge takes the bit
      repeat (2) @(posedge clk);
    end
    serial_select_n <= 1'b1;
    serial_data_input <= ~serial_data_input; // inverted, not left at the last value
    @(posedge clk);
  endtask
endmodule

// File: sim/dac_ctrl_chk.sv
/* pin-level checker for the converter control block.
   assumes the sampling clock and the asynchronous low reset. */
`timescale 1ns/1ps
module dac_ctrl_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic reset_pin,
  input wire logic power_ctrl_pin_1,
  input wire logic power_ctrl_pin_2,
  input wire logic power_ctrl_pin_3,
  input wire logic serial_shift_clock,
  input wire logic sample_strobe,
  // outputs
  input wire logic out_a_oe,
  input wire logic out_b_oe,
  input wire logic data_valid,
  input wire logic low_power,
  input wire logic low_speed,
  input wire logic format_select,
  input wire logic [1:0] config_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // pin decode as seen from outside; pins only count outside serial setup
  wire [2:0] pins = {power_ctrl_pin_1, power_ctrl_pin_2, power_ctrl_pin_3};
  wire pin_on = config_mode != 2'h0;
  wire pdn = pin_on && pins == 3'h4;
  logic [8:0] gap;
  logic [8:0] hi;
  ////////////////////////////////////////
  // strobe gap and reset-pin-high counters, saturating so they never wrap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap <= 9'h000;
      hi <= 9'h000;
    end else begin
      gap <= sample_strobe ? 9'h000 : gap + {8'h00, ~&gap};
      hi <= !reset_pin ? 9'h000 : hi + {8'h00, ~&hi};
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  pdn_float_a: assert property (
    pdn [*3] |-> !out_a_oe && !out_b_oe && !data_valid)
    else $error("outputs driven in power-down");
  pdn_wake_a: assert property (
    pdn [*4] ##1 !pdn |-> (!data_valid) [*3])
    else $error("data valid too soon after power-down");
  stby_a_a: assert property (
    (pin_on && pins == 3'h5) [*3] |-> !out_a_oe)
    else $error("channel a driven in standby");
  mux_a_a: assert property (
    (pin_on && pins == 3'h7) [*3] |-> !out_a_oe)
    else $error("channel a driven in interleaved mode");
  slow_clock_a: assert property (gap >= 9'h018 |-> low_power)
    else $error("no low power after strobe stopped");
  par_select_a: assert property (
    hi >= 9'h104 |-> config_mode == 2'h2)
    else $error("reset pin held high without pin setup");
  par_speed_a: assert property (
    (config_mode == 2'h2 && serial_shift_clock) [*3] |-> low_speed)
    else $error("low speed not taken from shift clock pin");
  ser_pins_a: assert property (
    (config_mode != 2'h2) [*2] |-> !low_speed && !format_select)
    else $error("pin functions active outside pin setup");
endmodule
bind dac_ctrl dac_ctrl_chk chk (
  .clk(clk),
  .resetn(resetn),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .reset_pin(reset_pin),
  .power_ctrl_pin_1(power_ctrl_pin_1),
  .power_ctrl_pin_2(power_ctrl_pin_2),
  .power_ctrl_pin_3(power_ctrl_pin_3),
  .serial_shift_clock(serial_shift_clock),
  .sample_strobe(sample_strobe),
  .out_a_oe(out_a_oe),
  .out_b_oe(out_b_oe),
  .data_valid(data_valid),
  .low_power(low_power),
  .low_speed(low_speed),
  .format_select(format_select),
  .config_mode(config_mode)
);

// File: sim/tb.sv
/* bench: bus tasks, sample history scoreboard, controller model on pins.
   assumes the block's header and a short wake-up parameter. */
`timescale 1ns/1ps
`include "dac_cfg.svh"
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic strobe = 1'b1;
  logic [13:0] raw_a = 14'h0000;
  logic [13:0] raw_b = 14'h0000;
  logic rd_pend = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rst_pin, p1, p2, p3, sn, sc, sd;
  wire [13:0] out_a, out_b;
  wire a_oe, b_oe, valid, low_power, low_speed, fmt;
  wire [1:0] cfg;
  int n_errors = 0;
  int checks = 0;
  int seed = 490;
  int lat = 0; // 0 turns sample checking off
  logic [31:0] rd_q[$];
  logic [13:0] hist[$];
  logic [13:0] histb[$];
  logic [2:0] modes[5] = '{3'h4, 3'h0, 3'h5, 3'h7, 3'h0};
  logic [1:0] oes[5] = '{2'h0, 2'h3, 2'h1, 2'h1, 2'h3};
  always #25 clk = ~clk;
  dac_ctrl #(.DW(14), .WAKE_GLOBAL(10), .WAKE_STBY(5)) dut (
    .clk(clk), .resetn(resetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .reset_pin(rst_pin), .power_ctrl_pin_1(p1),
    .power_ctrl_pin_2(p2), .power_ctrl_pin_3(p3), .serial_select_n(sn),
    .serial_shift_clock(sc), .serial_data_input(sd),
    .sample_strobe(strobe), .raw_a(raw_a), .raw_b(raw_b),
    .channel_a_output_bus(out_a), .channel_b_output_bus(out_b),
    .out_a_oe(a_oe), .out_b_oe(b_oe), .data_valid(valid),
    .low_power(low_power), .low_speed(low_speed), .format_select(fmt),
    .config_mode(cfg));
  dac_host host (
    .clk(clk), .reset_pin(rst_pin), .power_ctrl_pin_1(p1),
    .power_ctrl_pin_2(p2), .power_ctrl_pin_3(p3), .serial_select_n(sn),
    .serial_shift_clock(sc), .serial_data_input(sd));
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // single word transfer; waits on the slave's ready, never on a count
  task automatic bus(input logic [11:0] a, input logic w, logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // random samples on both channels
  always @(posedge clk) begin
    raw_a <= 14'($random(seed));
    raw_b <= 14'($random(seed));
  end
  // monitor: read data against the oldest note, output against history
  always @(posedge clk) begin
    if (rd_pend) cmp(hrdata, rd_q.pop_front());
    rd_pend <= htrans[1] && !hwrite && hreadyout;
    hist.push_front(raw_a);
    histb.push_front(raw_b);
    if (hist.size() > 24) void'(hist.pop_back());
    if (histb.size() > 24) void'(histb.pop_back());
    if (lat != 0 && valid === 1'b1 && hist.size() > lat)
      cmp({18'h0, out_a}, {18'h0, hist[lat]});
    if (lat != 0 && valid === 1'b1 && histb.size() > lat)
      cmp({18'h0, out_b}, {18'h0, histb[lat]});
  end
  // watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(`DAC_OFS_RESET, 32'h0);
    rd(`DAC_OFS_DIGEN, 32'h0);
    rd(`DAC_OFS_GAIN, 32'h0);
    rd(`DAC_OFS_DCCTL, 32'h2);
    rd(12'h030, 32'h0);
    lat <= 16;
    repeat (40) @(posedge clk);
    lat <= 0;
    bus(`DAC_OFS_DIGEN, 1'b1, 32'h1);
    repeat (30) @(posedge clk);
    lat <= 20;
    repeat (40) @(posedge clk);
    lat <= 0;
    bus(`DAC_OFS_DIGEN, 1'b1, 32'h0);
    bus(`DAC_OFS_GAIN, 1'b1, 32'hC);
    repeat (30) @(posedge clk);
    lat <= 16;
    repeat (40) @(posedge clk);
    lat <= 0;
    for (int g = 0; g < 14; g++) begin
      bus(`DAC_OFS_GAIN, 1'b1, 32'(g));
      rd(`DAC_OFS_GAIN, g < 13 ? 32'(g) : 32'hC);
    end
    for (int t = 0; t < 16; t++) begin
      bus(`DAC_OFS_DCCTL, 1'b1, 32'(t * 16 + 2));
      rd(`DAC_OFS_DCCTL, t < 12 ? 32'(t * 16 + 2) : 32'hB2);
    end
    bus(`DAC_OFS_DCCTL, 1'b1, 32'hB1);
    rd(`DAC_OFS_DCCTL, 32'hB1);
    bus(`DAC_OFS_RESET, 1'b1, 32'h1);
    @(posedge clk); // the bit stands for one cycle, then clears itself
    rd(`DAC_OFS_RESET, 32'h0);
    rd(`DAC_OFS_GAIN, 32'h0);
    rd(`DAC_OFS_DCCTL, 32'h2);
    host.send(16'h0205, 16);
    rd(`DAC_OFS_GAIN, 32'h5);
    rd(`DAC_OFS_SERIAL, 32'h0205);
    host.send(16'h0209, 12);
    rd(`DAC_OFS_GAIN, 32'h5);
    host.set(3'h0, 1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    host.set(3'h0, 1'b0, 1'b0, 1'b1);
    rd(`DAC_OFS_GAIN, 32'h0);
    for (int i = 0; i < 5; i++) begin
      host.set(modes[i], 1'b0, 1'b0, 1'b1);
      repeat (30) @(posedge clk);
      cmp({30'h0, a_oe, b_oe}, {30'h0, oes[i]});
    end
    // a power write hands power control to software: serial-only setup
    bus(`DAC_OFS_PWR, 1'b1, 32'h4);
    repeat (5) @(posedge clk);
    cmp({30'h0, cfg}, 32'h0);
    cmp({30'h0, a_oe, b_oe}, 32'h0);
    bus(`DAC_OFS_PWR, 1'b1, 32'h0);
    repeat (20) @(posedge clk);
    cmp({31'h0, low_power}, 32'h0);
    strobe <= 1'b0;
    repeat (30) @(posedge clk);
    cmp({31'h0, low_power}, 32'h1);
    strobe <= 1'b1;
    host.set(3'h0, 1'b1, 1'b1, 1'b1);
    repeat (300) @(posedge clk);
    cmp({30'h0, cfg}, 32'h2);
    cmp({31'h0, low_speed}, 32'h1);
    cmp({31'h0, fmt}, 32'h1);
    summarize();
  end
endmodule
